//--- design/dsio_pkg.sv
// package: register addresses, reset values and field positions of the dual six-bit port
package dsio_pkg;
    localparam logic [7:0] ADDR_STATUS   = 8'h03;
    localparam logic [7:0] ADDR_BANK_ONE = 8'h06;
    localparam logic [7:0] ADDR_BANK_TWO = 8'h07;
    localparam int         PORT_W        = 6;
    localparam logic [5:0] DIR_RESET     = 6'h3f;
    localparam logic [7:0] OPT_RESET     = 8'hff;
    localparam int         OPT_WAKE_DIS  = 7;
    localparam int         OPT_PULL_DIS  = 6;
    localparam int         OPT_TCLK_SEL  = 5;
    localparam int         STAT_WAKE_BIT = 7;
    localparam int         INPUT_ONLY    = 3;
    localparam int         TCLK_LINE     = 5;
    localparam logic [5:0] WAKE_GROUP    = 6'h1b;
    localparam logic [1:0] SEL_NONE      = 2'h0;
    localparam logic [1:0] SEL_ONE       = 2'h1;
    localparam logic [1:0] SEL_TWO       = 2'h2;
endpackage : dsio_pkg

//--- design/dsio_bank_if.sv
// interface: per-bank drive and read signals between the port top and its bank slices
`timescale 1ns/10ps
interface dsio_bank_if;
    logic [5:0] latch;
    logic [5:0] dir;
    logic [5:0] pins;
    logic [5:0] alt_mask;
    logic [5:0] force_in;
    logic [5:0] oe;
    logic [5:0] rd;
    modport top (output latch, output dir, output pins, output alt_mask, output force_in,
                 input oe, input rd);
    modport bank (input latch, input dir, input pins, input alt_mask, input force_in,
                  output oe, output rd);
endinterface : dsio_bank_if

//--- design/dsio_bank.sv
// bank slice: driver enable and masked pin read for one six-bit port
`timescale 1ns/10ps
module dsio_bank
(
    dsio_bank_if.bank b
);
    import dsio_pkg::*;
    genvar i;
    generate
        for (i = 0; i < PORT_W; i++)
        begin : g_line
            // a set direction bit or a forced input keeps the driver off
            assign b.oe[i] = ~b.dir[i] & ~b.force_in[i];
            // live pin, not the latch; alternate-function pins read zero
            assign b.rd[i] = b.pins[i] & ~b.alt_mask[i];
        end
    endgenerate
endmodule : dsio_bank

//--- design/dsio_port.sv
// top: two six-bit ports with direction registers; pull-ups and wake-on-change on bank one only
`timescale 1ns/10ps
// Operation
// - port reads return live pin levels
// - reset makes every pin a high-impedance input
// - upper two port bits read zero
// - input-only line never drives
// - alternate-function pins read as zero
// - group-wide pull-ups and wake on four lines
// - master clear line: no pull-up, no wake
// - direction load copies working register
// - direction one floats driver, zero drives latch
// - option bit forces timer clock line input
// - direction registers write-only, reset to ones
// - inputs not latched, sampled at read
// - output latch holds until rewritten
// - status bit 7 marks pin-change wake reset
// - bit set/clear writes whole pin image back
// - writes land cycle end, reads sample start
// - output pins lose pull-up and wake
module dsio_port
(
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // wake cause presented by the reset logic, taken on the first cycle after reset drops
    input  wire logic       WAKE_RESET,
    // configuration straps
    input  wire logic [5:0] ONE_ALT_MASK,
    input  wire logic [5:0] TWO_ALT_MASK,
    input  wire logic       MASTER_CLEAR_INPUT_ENABLE,
    // core file access
    input  wire logic [7:0] ADDR,
    input  wire logic       WR_EN,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       RD_EN,
    input  wire logic       BIT_OP,
    input  wire logic [2:0] BIT_SEL,
    input  wire logic       BIT_SET,
    output logic      [7:0] RD_DATA,
    // dedicated direction and option loads
    input  wire logic [1:0] DIR_LOAD_SEL,
    input  wire logic       OPT_LOAD,
    input  wire logic [7:0] W_REG,
    // pins of bank one
    input  wire logic [5:0] ONE_PIN_IN,
    output logic      [5:0] ONE_PIN_OUT,
    output logic      [5:0] ONE_PIN_OE,
    output logic      [5:0] ONE_PULLUP_EN,
    // pins of bank two
    input  wire logic [5:0] TWO_PIN_IN,
    output logic      [5:0] TWO_PIN_OUT,
    output logic      [5:0] TWO_PIN_OE,
    // wake and status
    output logic            WAKE_REQ,
    output logic            WAKE_FLAG
);
    import dsio_pkg::*;

    logic [5:0] one_latch;
    logic [5:0] two_latch;
    logic [5:0] one_dir;
    logic [5:0] two_dir;
    logic [7:0] options;
    logic       wake_flag;
    logic [5:0] wake_snap;
    logic [5:0] next_one_latch;
    logic [5:0] next_two_latch;
    logic [5:0] next_one_dir;
    logic [5:0] next_two_dir;
    logic [7:0] next_options;
    logic       next_wake_flag;
    logic [5:0] next_wake_snap;
    logic       rst_seen;
    logic       next_rst_seen;

    logic [7:0] rd_word;
    logic [5:0] one_group;
    logic [5:0] one_wake_lines;
    logic [5:0] rmw_val;
    logic [7:0] rmw_img;
    logic       wake_hit;
    logic [5:0] pull_lines;
    logic [5:0] next_two_force;

    // access decode
    logic       wr_one;
    logic       wr_two;
    logic       ld_one;
    logic       ld_two;

    // next values of the registered outputs
    logic [5:0] next_one_pin_oe;
    logic [5:0] next_two_pin_oe;
    logic [5:0] next_one_pin_out;
    logic [5:0] next_two_pin_out;
    logic [5:0] next_one_pullup_en;
    logic [7:0] next_rd_data;
    logic       next_wake_req;

    dsio_bank_if one_if ();
    dsio_bank_if two_if ();

    assign one_if.latch    = one_latch;
    assign one_if.dir      = one_dir;
    assign one_if.pins     = ONE_PIN_IN;
    assign one_if.alt_mask = ONE_ALT_MASK;
    assign one_if.force_in = 6'h01 << INPUT_ONLY;
    assign two_if.latch    = two_latch;
    assign two_if.dir      = two_dir;
    assign two_if.pins     = TWO_PIN_IN;
    assign two_if.alt_mask = TWO_ALT_MASK;
    // option bit hands the shared line to the timer clock input
    assign two_if.force_in = {options[OPT_TCLK_SEL], 5'h00} ;

    dsio_bank u_one
    (
        .b (one_if.bank)
    );

    dsio_bank u_two
    (
        .b (two_if.bank)
    );

    // access decode; file writes and direction loads are single-cycle strobes
    always_comb
    begin
        wr_one = WR_EN && (ADDR == ADDR_BANK_ONE);
        wr_two = WR_EN && (ADDR == ADDR_BANK_TWO);
        ld_one = (DIR_LOAD_SEL == SEL_ONE);
        ld_two = (DIR_LOAD_SEL == SEL_TWO);
    end

    // pull-up and wake group of bank one
    always_comb
    begin
        // master clear use removes the input-only line from the group
        one_group = WAKE_GROUP & ~({5'h00, MASTER_CLEAR_INPUT_ENABLE} << INPUT_ONLY);
        // an output pin never pulls up or wakes
        one_wake_lines = one_group & one_dir;
        // pull-ups follow the next direction, so they never overlap a driven pin
        pull_lines = one_group & next_one_dir;
        if (next_options[OPT_PULL_DIS])
        begin
            pull_lines = 6'h00;
        end
        // any change on a grouped input against last cycle's snapshot
        wake_hit = ~options[OPT_WAKE_DIS] &
                   (|((ONE_PIN_IN ^ wake_snap) & one_wake_lines));
    end

    // read path and read-modify-write image
    always_comb
    begin
        rd_word = 8'h00;
        case (ADDR)
            ADDR_BANK_ONE: rd_word = {2'h0, one_if.rd};
            ADDR_BANK_TWO: rd_word = {2'h0, two_if.rd};
            ADDR_STATUS:   rd_word = {wake_flag, 7'h00};
            default:       rd_word = 8'h00;
        endcase
        // read-modify-write starts from the pin image, not the latch
        rmw_img = rd_word;
        rmw_img[BIT_SEL] = BIT_SET;
        rmw_val = BIT_OP ? rmw_img[5:0] : WR_DATA[5:0];
    end

    // output latches
    always_comb
    begin
        next_one_latch = one_latch;
        next_two_latch = two_latch;
        // an input pin's latch is written too, ready for when it drives
        if (wr_one)
        begin
            next_one_latch = rmw_val;
        end
        if (wr_two)
        begin
            next_two_latch = rmw_val;
        end
    end

    // latches are not reset: their content is undefined until first written
    always_ff @(posedge CLK)
    begin
        one_latch <= next_one_latch;
        two_latch <= next_two_latch;
    end

    // direction registers, loaded only by the dedicated instruction
    always_comb
    begin
        next_one_dir = one_dir;
        next_two_dir = two_dir;
        if (ld_one)
        begin
            next_one_dir = W_REG[5:0];
        end
        if (ld_two)
        begin
            next_two_dir = W_REG[5:0];
        end
        if (RST)
        begin
            next_one_dir = DIR_RESET;
            next_two_dir = DIR_RESET;
        end
    end

    always_ff @(posedge CLK)
    begin
        one_dir <= next_one_dir;
        two_dir <= next_two_dir;
    end

    // option register; only bits 7 to 5 matter here, the rest feed the timer
    always_comb
    begin
        next_options = options;
        if (OPT_LOAD)
        begin
            next_options = W_REG;
        end
        if (RST)
        begin
            next_options = OPT_RESET;
        end
    end

    always_ff @(posedge CLK)
    begin
        options <= next_options;
    end

    // wake cause and pin snapshot
    always_comb
    begin
        next_wake_flag = wake_flag;
        next_wake_snap = ONE_PIN_IN;
        next_rst_seen  = RST;
        if (RST)
        begin
            next_wake_flag = 1'b0;
        end
        else if (rst_seen)
        begin
            // cause is taken once, on the first cycle after reset drops
            next_wake_flag = WAKE_RESET;
        end
    end

    always_ff @(posedge CLK)
    begin
        wake_flag <= next_wake_flag;
        wake_snap <= next_wake_snap;
        rst_seen  <= next_rst_seen;
    end

    // pin drive; a write this cycle reaches the pin at the cycle end
    always_comb
    begin
        // option bit hands the shared line to the timer clock input
        next_two_force     = {next_options[OPT_TCLK_SEL], 5'h00};
        next_one_pin_out   = next_one_latch;
        next_two_pin_out   = next_two_latch;
        next_one_pin_oe    = ~next_one_dir & ~one_if.force_in;
        next_two_pin_oe    = ~next_two_dir & ~next_two_force;
        next_one_pullup_en = pull_lines;
        if (RST)
        begin
            next_one_pin_oe    = 6'h00;
            next_two_pin_oe    = 6'h00;
            next_one_pin_out   = 6'h00;
            next_two_pin_out   = 6'h00;
            next_one_pullup_en = 6'h00;
        end
    end

    always_ff @(posedge CLK)
    begin
        ONE_PIN_OE    <= next_one_pin_oe;
        TWO_PIN_OE    <= next_two_pin_oe;
        ONE_PIN_OUT   <= next_one_pin_out;
        TWO_PIN_OUT   <= next_two_pin_out;
        ONE_PULLUP_EN <= next_one_pullup_en;
    end

    // core side: read data stands until the next read
    always_comb
    begin
        next_rd_data  = RD_DATA;
        next_wake_req = wake_hit;
        // pins sampled in the cycle of the read request
        if (RD_EN)
        begin
            next_rd_data = rd_word;
        end
        if (RST)
        begin
            next_rd_data  = 8'h00;
            next_wake_req = 1'b0;
        end
    end

    always_ff @(posedge CLK)
    begin
        RD_DATA   <= next_rd_data;
        WAKE_REQ  <= next_wake_req;
        WAKE_FLAG <= next_wake_flag;
    end
    // direction and option registers have no read path
endmodule : dsio_port

//--- tb/dsio_port_props.sv
// checker: concurrent properties on the port top
`timescale 1ns/10ps
module dsio_port_props
(
    // clock and reset
    input wire logic       CLK,
    input wire logic       RST,
    // file access
    input wire logic [7:0] ADDR,
    input wire logic       WR_EN,
    input wire logic [7:0] WR_DATA,
    input wire logic       BIT_OP,
    input wire logic       RD_EN,
    input wire logic [7:0] RD_DATA,
    input wire logic [1:0] DIR_LOAD_SEL,
    input wire logic [7:0] W_REG,
    input wire logic       MASTER_CLEAR_INPUT_ENABLE,
    // pins
    input wire logic [5:0] ONE_ALT_MASK,
    input wire logic [5:0] ONE_PIN_IN,
    input wire logic [5:0] ONE_PIN_OUT,
    input wire logic [5:0] ONE_PIN_OE,
    input wire logic [5:0] ONE_PULLUP_EN,
    input wire logic [5:0] TWO_PIN_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    in_only_a: assert property (!ONE_PIN_OE[3]) else $error("line 3 driven");
    top_zero_a: assert property (RD_EN && ADDR[7:1] == 7'h03 |=> RD_DATA[7:6] == 2'h0)
        else $error("bits 7:6 set");
    pin_read_a: assert property (RD_EN && ADDR == 8'h06 |=>
        RD_DATA[5:0] == ($past(ONE_PIN_IN) & ~$past(ONE_ALT_MASK))) else $error("bad read");
    out_pull_a: assert property ((ONE_PIN_OE & ONE_PULLUP_EN) == 6'h00)
        else $error("pull-up on output");
    grp_pull_a: assert property ((ONE_PULLUP_EN & 6'h24) == 6'h00)
        else $error("pull-up off group");
    master_clear_input_pull_a: assert property (MASTER_CLEAR_INPUT_ENABLE && $past(MASTER_CLEAR_INPUT_ENABLE) |-> !ONE_PULLUP_EN[3])
        else $error("pull-up on clear line");
    wr_latch_a: assert property (WR_EN && ADDR == 8'h06 && !BIT_OP |=>
        ONE_PIN_OUT == $past(WR_DATA[5:0])) else $error("latch not written");
    dir_load_a: assert property (DIR_LOAD_SEL == 2'h1 |=>
        ONE_PIN_OE == (~$past(W_REG[5:0]) & 6'h37)) else $error("bad drive enable");
    rst_float_a: assert property (disable iff (1'b0) RST |=>
        ONE_PIN_OE == 6'h00 && TWO_PIN_OE == 6'h00) else $error("driven after reset");
endmodule : dsio_port_props
bind dsio_port dsio_port_props i_props (.*);

//--- tb/dsio_pin_model.sv
// pin model: outside drive, weak pull-up and floating level of one bank
`timescale 1ns/10ps
module dsio_pin_model
(
    // clock
    input  wire logic       clk,
    // device side
    input  wire logic [5:0] oe,
    input  wire logic [5:0] out,
    input  wire logic [5:0] pu,
    // bench side
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] level
);
    logic tog = 1'b0;
    // a floating pin flips each cycle so a stale value never passes for a read
    always_ff @(posedge clk) tog <= ~tog;
    assign level = (ext_en & ext_val) | (~ext_en & oe & out) | (~ext_en & ~oe & (pu | {6{tog}}));
endmodule : dsio_pin_model

//--- tb/dsio_port_tb_top.sv
// testbench: directed scenarios for the dual six-bit port
`timescale 1ns/10ps
module dsio_port_tb_top;
    import dsio_pkg::*;
    logic CLK = 0, RST = 1, WAKE_RESET = 0, MASTER_CLEAR_INPUT_ENABLE = 0, WR_EN = 0, RD_EN = 0;
    logic BIT_OP = 0, BIT_SET = 0, OPT_LOAD = 0, WAKE_REQ, WAKE_FLAG;
    logic [7:0] ADDR = 0, WR_DATA = 0, W_REG = 0, RD_DATA;
    logic [2:0] BIT_SEL = 0;
    logic [1:0] DIR_LOAD_SEL = 0;
    logic [5:0] ONE_ALT_MASK = 0, TWO_ALT_MASK = 0, ext_en1 = 0, ext_v1 = 0, ext_en2 = 0;
    logic [5:0] ext_v2 = 0, ONE_PIN_IN, ONE_PIN_OUT, ONE_PIN_OE, ONE_PULLUP_EN;
    logic [5:0] TWO_PIN_IN, TWO_PIN_OUT, TWO_PIN_OE;
    int n_mismatch = 0;
    int total_checks = 0;
    dsio_port i_dut (.*);
    dsio_pin_model i_one (.clk(CLK), .oe(ONE_PIN_OE), .out(ONE_PIN_OUT), .pu(ONE_PULLUP_EN),
        .ext_en(ext_en1), .ext_val(ext_v1), .level(ONE_PIN_IN));
    dsio_pin_model i_two (.clk(CLK), .oe(TWO_PIN_OE), .out(TWO_PIN_OUT), .pu(6'h00),
        .ext_en(ext_en2), .ext_val(ext_v2), .level(TWO_PIN_IN));
    initial forever #20 CLK = ~CLK;
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic op);
        @(negedge CLK);
        {ADDR, WR_DATA, BIT_OP, WR_EN} = {a, d, op, 1'b1};
        @(negedge CLK);
        WR_EN = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(negedge CLK);
        {ADDR, RD_EN} = {a, 1'b1};
        @(negedge CLK);
        RD_EN = 1'b0;
        check(RD_DATA, want);
    endtask : rd
    task automatic ld(input logic [1:0] sel, input logic [7:0] w, input logic opt);
        @(negedge CLK);
        {DIR_LOAD_SEL, W_REG, OPT_LOAD} = {sel, w, opt};
        @(negedge CLK);
        {DIR_LOAD_SEL, OPT_LOAD} = 3'h0;
    endtask : ld
    task automatic t_reset();
        RST = 1'b1;
        repeat (2) @(negedge CLK);
        check({2'h0, ONE_PIN_OE | TWO_PIN_OE}, 8'h00);
        RST = 1'b0;
        repeat (4) @(negedge CLK);
        check({7'h0, WAKE_FLAG}, {7'h0, WAKE_RESET});
        check({2'h0, ONE_PIN_OE | TWO_PIN_OE}, 8'h00);
        rd(ADDR_STATUS, {WAKE_RESET, 7'h00});
        $display("reset test done");
    endtask : t_reset
    task automatic t_drive();
        wr(ADDR_BANK_ONE, 8'h15, 1'b0);
        check({2'h0, ONE_PIN_OUT | ONE_PIN_OE}, 8'h15);
        ld(SEL_ONE, 8'h00, 1'b0);
        check({2'h0, ONE_PIN_OE}, 8'h37);
        check({2'h0, ONE_PIN_OUT}, 8'h15);
        {ext_en1, ext_v1} = {6'h09, 6'h08};
        rd(ADDR_BANK_ONE, 8'h1c);
        ONE_ALT_MASK = 6'h30;
        rd(ADDR_BANK_ONE, 8'h0c);
        ONE_ALT_MASK = 6'h00;
        $display("drive test done");
    endtask : t_drive
    task automatic t_pull();
        ld(SEL_TWO, 8'h00, 1'b0);
        check({2'h0, TWO_PIN_OE}, 8'h1f);
        ld(SEL_NONE, 8'h9f, 1'b1);
        check({2'h0, TWO_PIN_OE}, 8'h3f);
        check({2'h0, ONE_PULLUP_EN}, 8'h00);
        ld(SEL_ONE, 8'h3f, 1'b0);
        check({2'h0, ONE_PULLUP_EN}, 8'h1b);
        MASTER_CLEAR_INPUT_ENABLE = 1'b1;
        ld(SEL_ONE, 8'h3e, 1'b0);
        check({2'h0, ONE_PULLUP_EN}, 8'h12);
        MASTER_CLEAR_INPUT_ENABLE = 1'b0;
        $display("pull-up test done");
    endtask : t_pull
    task automatic t_wake();
        {ext_en1, ext_v1} = 12'h000;
        ld(SEL_ONE, 8'h3f, 1'b0);
        // wake on, pull-ups on, shared line back to plain I/O
        ld(SEL_NONE, 8'h1f, 1'b1);
        @(negedge CLK);
        check({7'h0, WAKE_REQ}, 8'h00);
        {ext_en1, ext_v1} = {6'h10, 6'h00};
        @(negedge CLK);
        check({7'h0, WAKE_REQ}, 8'h01);
        // the freed clear line floats and toggles, yet must not wake
        MASTER_CLEAR_INPUT_ENABLE = 1'b1;
        repeat (3) @(negedge CLK);
        check({7'h0, WAKE_REQ}, 8'h00);
        MASTER_CLEAR_INPUT_ENABLE = 1'b0;
        {ext_en1, ext_v1} = 12'h000;
        $display("wake test done");
    endtask : t_wake
    task automatic t_bitop();
        wr(ADDR_BANK_TWO, 8'h00, 1'b0);
        ld(SEL_TWO, 8'h01, 1'b0);
        {ext_en2, ext_v2, BIT_SEL, BIT_SET} = {6'h01, 6'h01, 3'h5, 1'b1};
        wr(ADDR_BANK_TWO, 8'h00, 1'b1);
        check({2'h0, TWO_PIN_OUT}, 8'h21);
        wr(ADDR_BANK_TWO, 8'hff, 1'b0);
        // one idle cycle lets the pins settle before the read
        @(negedge CLK);
        rd(ADDR_BANK_TWO, 8'h3f);
        $display("bit op test done");
    endtask : t_bitop
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial
    begin
        repeat (3000) @(posedge CLK);
        n_mismatch++;
        results();
    end
    initial
    begin
        t_reset();
        t_drive();
        t_pull();
        t_wake();
        t_bitop();
        WAKE_RESET = 1'b1;
        t_reset();
        results();
    end
endmodule : dsio_port_tb_top
